// >>> common/sewts_defs.vh
`ifndef SEWTS_DEFS_VH
`define SEWTS_DEFS_VH
// =====================================================
// Device address word
`define SEWTS_TYPE_CODE 4'ha
// =====================================================
// Sizes: 1K=0 2K=1 4K=2 8K=3 16K=4
`define SEWTS_SIZE_1K 3'h0
`define SEWTS_SIZE_2K 3'h1
`define SEWTS_SIZE_4K 3'h2
`define SEWTS_SIZE_8K 3'h3
`define SEWTS_SIZE_16K 3'h4
// =====================================================
// Write cycle timing
`define SEWTS_WR_TIME_MS 5
`define SEWTS_CLK_HZ 20000000
`define SEWTS_WR_CYCLES ((`SEWTS_WR_TIME_MS * `SEWTS_CLK_HZ) / 1000)
// =====================================================
// Page buffer
`define SEWTS_FIFO_DEPTH 32
`define SEWTS_FIFO_AW 5
`endif

// >>> design/sewts_fifo.v
`timescale 1ns/100ps
`include "sewts_defs.vh"
module sewts_fifo #(
    parameter WIDTH = 19,
    parameter DEPTH = `SEWTS_FIFO_DEPTH,
    parameter AW = `SEWTS_FIFO_AW
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire [AW:0] count = wr_q - rd_q;
    wire full = (count == DEPTH);
    wire empty = (wr_q == rd_q);
    wire pop = !empty && (!out_valid || out_ready);
    assign in_ready = !full;
    always @(posedge clk) begin
        if (in_valid && !full) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
                out_data <= mem_q[rd_q[AW-1:0]];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule // sewts_fifo

// >>> design/sewts_slave.v
`timescale 1ns/100ps
`include "sewts_defs.vh"
module sewts_slave #(
    parameter WR_CYCLES = `SEWTS_WR_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Configuration
    input wire [2:0] size_sel,
    input wire chip_select_in_2,
    input wire chip_select_in_1,
    input wire chip_select_in_0,
    input wire write_protect,
    // Two-wire pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    // Array write port
    output reg mem_wr_valid,
    input wire mem_wr_ready,
    output reg [10:0] mem_wr_addr,
    output reg [7:0] mem_wr_data,
    // Status
    output reg standby,
    output reg write_busy
);
    localparam ST_IDLE = 3'h0;
    localparam ST_DEV = 3'h1;
    localparam ST_WADDR = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_IGNORE = 3'h4;
    // =====================================================
    // Pin synchronisers
    reg scl_m_q, scl_s_q, scl_p_q;
    reg sda_m_q, sda_s_q, sda_p_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end
    wire scl_rise = scl_s_q && !scl_p_q;
    wire scl_fall = !scl_s_q && scl_p_q;
    wire start_cond = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    wire stop_cond = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
    // =====================================================
    // Protocol state
    reg [2:0] state_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg ack_q;
    reg [10:0] addr_q;
    reg [2:0] page_q;
    reg wrote_q;
    reg [31:0] wr_cnt_q;
    reg fifo_in_valid_q;
    reg [18:0] fifo_in_data_q;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [18:0] fifo_out_data;
    wire small_part = (size_sel == `SEWTS_SIZE_1K) || (size_sel == `SEWTS_SIZE_2K);
    wire [7:0] rx_byte = {shift_q[6:0], sda_s_q};
    reg dev_match;
    reg [2:0] page_bits;
    always @* begin
        dev_match = (rx_byte[7:4] == `SEWTS_TYPE_CODE);
        page_bits = 3'h0;
        case (size_sel)
            `SEWTS_SIZE_1K, `SEWTS_SIZE_2K: begin
                dev_match = dev_match && (rx_byte[3:1] ==
                    {chip_select_in_2, chip_select_in_1, chip_select_in_0});
            end
            `SEWTS_SIZE_4K: begin
                dev_match = dev_match && (rx_byte[3:2] == {chip_select_in_2, chip_select_in_1});
                page_bits = {2'h0, rx_byte[1]};
            end
            `SEWTS_SIZE_8K: begin
                dev_match = dev_match && (rx_byte[3] == chip_select_in_2);
                page_bits = {1'h0, rx_byte[2:1]};
            end
            default: begin
                page_bits = rx_byte[3:1];
            end
        endcase
    end
    // Draining must finish before the timed cycle ends, so busy also waits on the buffer
    wire drain_busy = fifo_out_valid || fifo_in_valid_q || mem_wr_valid;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ack_q <= 1'b0;
            addr_q <= 11'h000;
            page_q <= 3'h0;
            wrote_q <= 1'b0;
            wr_cnt_q <= 32'h0;
            write_busy <= 1'b0;
            standby <= 1'b1;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            fifo_in_valid_q <= 1'b0;
            fifo_in_data_q <= 19'h00000;
        end else begin
            fifo_in_valid_q <= 1'b0;
            if (write_busy) begin
                // Bus pins are ignored while the cycle runs
                if (wr_cnt_q != 32'h0) begin
                    wr_cnt_q <= wr_cnt_q - 32'h1;
                end else if (!drain_busy) begin
                    write_busy <= 1'b0;
                    standby <= 1'b1;
                end
                sda_oe <= 1'b0;
                state_q <= ST_IDLE;
            end else if (stop_cond) begin
                state_q <= ST_IDLE;
                sda_oe <= 1'b0;
                if (wrote_q) begin
                    write_busy <= 1'b1;
                    wr_cnt_q <= WR_CYCLES - 1;
                    wrote_q <= 1'b0;
                end else begin
                    standby <= 1'b1;
                end
            end else if (start_cond) begin
                state_q <= ST_DEV;
                bit_q <= 4'h0;
                ack_q <= 1'b0;
                sda_oe <= 1'b0;
                standby <= 1'b0;
            end else if (state_q != ST_IDLE) begin
                if (scl_rise && !ack_q) begin
                    shift_q <= rx_byte;
                    bit_q <= bit_q + 4'h1;
                    if (bit_q == 4'h7) begin
                        case (state_q)
                            ST_DEV: begin
                                if (dev_match && !rx_byte[0]) begin
                                    ack_q <= 1'b1;
                                    page_q <= page_bits;
                                    state_q <= ST_WADDR;
                                end else if (dev_match) begin
                                    ack_q <= 1'b1; // Read path lies outside this block
                                    state_q <= ST_IGNORE;
                                end else begin
                                    state_q <= ST_IDLE;
                                    standby <= 1'b1;
                                end
                            end
                            ST_WADDR: begin
                                ack_q <= 1'b1;
                                addr_q <= {page_q, rx_byte};
                                state_q <= ST_DATA;
                            end
                            ST_DATA: begin
                                ack_q <= 1'b1;
                                if (!write_protect && fifo_in_ready) begin
                                    fifo_in_valid_q <= 1'b1;
                                    fifo_in_data_q <= {addr_q, rx_byte};
                                    wrote_q <= 1'b1;
                                end
                                if (small_part) begin
                                    addr_q[2:0] <= addr_q[2:0] + 3'h1;
                                end else begin
                                    addr_q[3:0] <= addr_q[3:0] + 4'h1;
                                end
                            end
                            default: begin
                                state_q <= ST_IDLE;
                            end
                        endcase
                    end
                end else if (scl_fall) begin
                    if (ack_q && bit_q == 4'h8) begin
                        sda_out <= 1'b0;
                        sda_oe <= 1'b1;
                        bit_q <= 4'h9;
                    end else if (bit_q == 4'h9) begin
                        sda_oe <= 1'b0;
                        ack_q <= 1'b0;
                        bit_q <= 4'h0;
                        if (state_q == ST_IGNORE) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end else if (scl_rise && bit_q == 4'h8) begin
                    bit_q <= bit_q; // Ack clock high seen before release
                end
            end
        end
    end
    // =====================================================
    // Page buffer toward the array
    sewts_fifo #(
        .WIDTH(19),
        .DEPTH(`SEWTS_FIFO_DEPTH),
        .AW(`SEWTS_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(fifo_in_valid_q),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data_q),
        .out_valid(fifo_out_valid),
        .out_ready(!mem_wr_valid || mem_wr_ready),
        .out_data(fifo_out_data)
    );
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_wr_valid <= 1'b0;
            mem_wr_addr <= 11'h000;
            mem_wr_data <= 8'h00;
        end else if (!mem_wr_valid || mem_wr_ready) begin
            mem_wr_valid <= fifo_out_valid;
            mem_wr_addr <= fifo_out_data[18:8];
            mem_wr_data <= fifo_out_data[7:0];
        end
    end
endmodule // sewts_slave

// >>> dv/sewts_slave_asserts.sv
`timescale 1ns/100ps
module sewts_slave_asserts #(
    parameter WR_CYCLES = 100000
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Pins
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    // Array port
    input wire mem_wr_valid,
    input wire mem_wr_ready,
    input wire [10:0] mem_wr_addr,
    input wire [7:0] mem_wr_data,
    // Status
    input wire standby,
    input wire write_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    reg [31:0] busy_q;
    always @(posedge clk or posedge rst) begin
        if (rst) busy_q <= 32'h0;
        else busy_q <= write_busy ? busy_q + 32'h1 : 32'h0;
    end
    sequence s_stall; mem_wr_valid && !mem_wr_ready; endsequence
    sequence s_busy_end; $fell(write_busy); endsequence
    a_drive_low: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    a_ack_scl_low: assert property ($rose(sda_oe) || $fell(sda_oe) |-> !scl_in)
        else $error("ack edge with scl high");
    a_ack_held: assert property (sda_oe && scl_in |=> sda_oe)
        else $error("ack dropped in high");
    a_busy_no_ack: assert property (write_busy |-> !sda_oe)
        else $error("ack while busy");
    a_busy_awake: assert property (write_busy || mem_wr_valid |-> !standby)
        else $error("standby while working");
    a_busy_on_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
        else $error("busy without stop");
    a_idle_after: assert property (s_busy_end |-> ##[0:2] standby)
        else $error("no standby after cycle");
    a_cycle_long: assert property (s_busy_end |-> busy_q >= WR_CYCLES)
        else $error("write cycle short");
    a_cycle_bound: assert property (busy_q <= WR_CYCLES + 256)
        else $error("write cycle long");
    a_stall_holds: assert property (s_stall |=> mem_wr_valid && $stable(mem_wr_addr)
        && $stable(mem_wr_data)) else $error("write request moved");
endmodule // sewts_slave_asserts
bind sewts_slave sewts_slave_asserts #(.WR_CYCLES(WR_CYCLES)) u_chk (.clk(clk),
    .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .standby(standby), .write_busy(write_busy));

// >>> dv/sewts_ctrl_model.sv
`timescale 1ns/100ps
module sewts_ctrl_model (
    // Clock
    input wire clk,
    // Bus lines
    output reg scl,
    output reg sda_drv,
    input wire sda
);
    // =====================================================
    // Bus controller, 400 ns bit time, lines idle high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task q;
        repeat (2) @(negedge clk);
    endtask
    task bus_start;
        sda_drv = 1'b1;
        scl = 1'b1;
        q;
        sda_drv = 1'b0;
        q;
        scl = 1'b0;
        q;
    endtask
    task bus_stop;
        sda_drv = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_drv = 1'b1;
        q;
        q;
    endtask
    task send_byte(input [7:0] b, output ack);
        integer i;
        for (i = 7; i >= -1; i = i - 1) begin
            sda_drv = (i >= 0) ? b[i] : 1'b1;
            q;
            scl = 1'b1;
            q;
            ack = ~sda;
            q;
            scl = 1'b0;
            q;
        end
    endtask
    task clock_bit(input b, output s);
        sda_drv = b;
        q;
        scl = 1'b1;
        q;
        s = sda;
        q;
        scl = 1'b0;
        q;
    endtask
    // Clocks until the line is seen free, at most nine times, then starts afresh
    task bus_recover(output integer n);
        reg s;
        s = 1'b0;
        n = 0;
        while (n < 9 && s !== 1'b1) begin
            clock_bit(1'b1, s);
            n = n + 1;
        end
        bus_start();
    endtask
endmodule // sewts_ctrl_model

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
    // =====================================================
    // Stimulus and wires
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [2:0] size_sel = 3'h1;
    reg [2:0] cs = 3'h5;
    reg wp = 1'b0;
    reg rdy = 1'b0;
    reg [3:0] stall_q = 4'h0;
    reg ack;
    reg [18:0] wq[$];
    integer err_count = 0;
    integer samples_checked = 0;
    wire scl, sda_drv, sda_out, sda_oe, valid, standby, busy;
    wire [10:0] addr;
    wire [7:0] data;
    // Pull-up wins unless someone pulls low
    wire sda = sda_drv & ~sda_oe;
    always #25 clk = ~clk;
    sewts_slave #(.WR_CYCLES(200)) dut (.clk(clk), .rst(rst), .size_sel(size_sel),
        .chip_select_in_2(cs[2]), .chip_select_in_1(cs[1]), .chip_select_in_0(cs[0]),
        .write_protect(wp), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .mem_wr_valid(valid), .mem_wr_ready(rdy), .mem_wr_addr(addr), .mem_wr_data(data),
        .standby(standby), .write_busy(busy));
    sewts_ctrl_model ctrl (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
    // Array stalls one cycle in four
    always @(negedge clk) begin
        stall_q <= stall_q + 4'h1;
        rdy <= (stall_q[1:0] != 2'h3);
    end
    always @(posedge clk) if (valid && rdy) wq.push_back({addr, data});
    // =====================================================
    // Checks
    task chk_bit(input got, input exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error %0t: bit %b want %b", $time, got, exp);
        end
    endtask
    task chk_word(input [18:0] got, input [18:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error %0t: word %h want %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("Checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // =====================================================
    // Scenarios
    task do_write(input [7:0] dev, input [7:0] wa, input integer n, input [2:0] up,
        input [7:0] pm);
        integer i;
        wq.delete();
        ctrl.bus_start();
        ctrl.send_byte(dev, ack);
        chk_bit(ack, 1'b1);
        ctrl.send_byte(wa, ack);
        chk_bit(ack, 1'b1);
        for (i = 0; i < n; i = i + 1) begin
            ctrl.send_byte(8'h10 + i[7:0], ack);
            chk_bit(ack, 1'b1);
        end
        ctrl.bus_stop();
        repeat (2) @(negedge clk);
        chk_bit(busy, ~wp);
        ctrl.bus_start();
        ctrl.send_byte(dev, ack);
        chk_bit(ack, wp);
        ctrl.bus_stop();
        for (i = 0; i < 600 && busy !== 1'b0; i = i + 1) @(negedge clk);
        chk_bit(busy, 1'b0);
        chk_bit(standby, 1'b1);
        ctrl.bus_start();
        ctrl.send_byte(dev, ack);
        chk_bit(ack, 1'b1);
        ctrl.bus_stop();
        chk_word(19'(wq.size()), wp ? 19'h0 : 19'(n));
        for (i = 0; i < wq.size(); i = i + 1)
            chk_word(wq[i], {up, (wa & ~pm) | ((wa + i[7:0]) & pm), 8'h10 + i[7:0]});
    endtask
    // Abort right after the address word; the ack still holds the line on the first clock
    task recover_run(input [7:0] dev);
        integer i;
        integer n;
        reg s;
        ctrl.bus_start();
        for (i = 7; i >= 0; i = i - 1) ctrl.clock_bit(dev[i], s);
        ctrl.bus_recover(n);
        chk_word(n[18:0], 19'h2);
        ctrl.send_byte(dev, ack);
        chk_bit(ack, 1'b1);
        ctrl.bus_stop();
        chk_bit(standby, 1'b1);
    endtask
    task no_match(input [7:0] dev, input exp);
        ctrl.bus_start();
        ctrl.send_byte(dev, ack);
        chk_bit(ack, exp);
        repeat (4) @(negedge clk);
        chk_bit(standby, ~exp);
        ctrl.bus_stop();
    endtask
    initial begin
        #2000000;
        err_count = err_count + 1;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        chk_bit(standby, 1'b1);
        chk_bit(busy | sda_oe, 1'b0);
        do_write(8'haa, 8'h3e, 3, 3'h0, 8'h07);
        no_match(8'ha8, 1'b0);
        no_match(8'hba, 1'b0);
        no_match(8'hab, 1'b1);
        recover_run(8'haa);
        size_sel = 3'h4;
        do_write(8'hac, 8'h4e, 18, 3'h6, 8'h0f);
        size_sel = 3'h2;
        do_write(8'haa, 8'hf0, 1, 3'h1, 8'h0f);
        size_sel = 3'h3;
        do_write(8'hae, 8'h21, 1, 3'h3, 8'h0f);
        size_sel = 3'h0;
        wp = 1'b1;
        do_write(8'haa, 8'h00, 2, 3'h0, 8'h07);
        tally_and_finish;
    end
endmodule // tb
